/* File: rtl/mac_pkg.sv */
// Shared constants and types for the monitor converter serial control
package mac_pkg;
  // Result and configuration word sizes
  localparam int RES_W = 10;
  localparam int CFG_TAIL = 3;
  localparam int IDX_W = 5;
  // Shift index marks: end of first result copy, end of second copy
  localparam logic [IDX_W-1:0] IDX_ZERO = 5'h00;
  localparam logic [IDX_W-1:0] IDX_ONE = 5'h01;
  localparam logic [IDX_W-1:0] IDX_RES_END = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_ALL_END = 5'h14;
  // Configuration tail counter values
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_LAST = 2'h2;
  // Measurement modes
  localparam logic [1:0] MODE_TEMP = 2'h0;
  localparam logic [1:0] MODE_SUPPLY = 2'h1;
  localparam logic [1:0] MODE_DIFF_1V = 2'h2;
  localparam logic [1:0] MODE_DIFF_HALF = 2'h3;
  localparam logic [1:0] MODE_RST = MODE_SUPPLY;
  localparam logic [RES_W-1:0] CODE_RST = 10'h000;
  // Exchange states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_HUNT = 5'b0_0010,
    ST_CFG = 5'b0_0100,
    ST_CONV = 5'b0_1000,
    ST_SHIFT = 5'b1_0000
  } mac_state_t;
endpackage

/* File: rtl/mac_edge.sv */
// Edge detector for the host shift clock
`timescale 1ns/1ps
module mac_edge (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclk,
  output logic sclk_rise,
  output logic sclk_fall
);
  logic sclk_prev_ff;
  logic nxt_sclk_prev;

  // Next value of the delayed shift clock
  always_comb begin
    nxt_sclk_prev = sclk;
  end

  // Register delayed shift clock
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= nxt_sclk_prev;
    end
  end

  // Edges seen in the cycle the new level arrives
  assign sclk_rise = sclk & ~sclk_prev_ff;
  assign sclk_fall = ~sclk & sclk_prev_ff;
endmodule // mac_edge

/* File: rtl/mac_ctrl.sv */
// Serial control of the temperature, supply and differential monitor
// Functional notes
// - Bits are launched on the shift clock falling edge and taken on its rising edge.
// - The word is received first and the result sent afterwards, so data in and out may share a wire.
// - The first one sampled after select falls is the start bit and earlier zeros are ignored.
// - The word is start, upper mode, lower mode, order flag; the three bits after start are kept.
// - After the word is complete further input is ignored until select goes high and low again.
// - Mode 00 is temperature, 01 supply, 10 differential 1 V, 11 differential 0.5 V.
// - On the first falling edge after the word is captured the serial output leaves high impedance and is driven.
// - One null bit goes out on a falling edge, then the 10-bit result, one bit per falling edge.
// - With the order flag at one the result goes MSB first, then zeros while select stays low.
// - With the order flag at zero the result goes MSB first and then again LSB first.
// - Select low enables the device and select high resets the serial interface.
// - A temperature result is an unsigned 10-bit code rising a quarter degree per step.
`timescale 1ns/1ps
module mac_ctrl #(
  parameter int RES_W = mac_pkg::RES_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic conv_start,
  output logic [1:0] meas_mode,
  output logic mode_is_temp,
  output logic temp_after_change,
  output logic output_order_flag,
  input wire logic conv_valid,
  input wire logic [RES_W-1:0] conv_code
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  mac_pkg::mac_state_t state_ff;
  mac_pkg::mac_state_t nxt_state;
  logic sclk_rise;
  logic sclk_fall;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [2:0] cfg_ff;
  logic [2:0] nxt_cfg;
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic order_ff;
  logic nxt_order;
  logic start_ff;
  logic nxt_start;
  logic prev_temp_ff;
  logic nxt_prev_temp;
  logic chg_ff;
  logic nxt_chg;
  logic [mac_pkg::IDX_W-1:0] idx_ff;
  logic [mac_pkg::IDX_W-1:0] nxt_idx;
  logic sdo_ff;
  logic nxt_sdo;
  logic oe_ff;
  logic nxt_oe;
  logic [RES_W-1:0] code_ff;
  logic [RES_W-1:0] nxt_code;
  logic [mac_pkg::IDX_W-1:0] msb_sel;
  logic [mac_pkg::IDX_W-1:0] lsb_sel;
  logic out_bit;

  ////////////////////////////////////////////////////////////////////////
  // Shift clock edges
  mac_edge u_mac_edge (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sclk(sclk),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bit chosen for the next falling edge
  always_comb begin
    msb_sel = mac_pkg::IDX_W'(RES_W - 1) - idx_ff;
    lsb_sel = idx_ff - mac_pkg::IDX_RES_END;
    if (idx_ff < mac_pkg::IDX_RES_END) begin
      out_bit = code_ff[msb_sel[3:0]];
    end else if (!order_ff && idx_ff < mac_pkg::IDX_ALL_END) begin
      out_bit = code_ff[lsb_sel[3:0]];
    end else begin
      out_bit = 1'b0;
    end
  end

  // Exchange sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cfg = cfg_ff;
    nxt_mode = mode_ff;
    nxt_order = order_ff;
    nxt_start = 1'b0;
    nxt_prev_temp = prev_temp_ff;
    nxt_chg = chg_ff;
    nxt_idx = idx_ff;
    nxt_sdo = sdo_ff;
    nxt_oe = oe_ff;
    if (cs_n) begin
      // Select high resets the interface and floats the output
      nxt_state = mac_pkg::ST_IDLE;
      nxt_oe = 1'b0;
      nxt_sdo = 1'b0;
      nxt_cnt = mac_pkg::CNT_ZERO;
      nxt_idx = mac_pkg::IDX_ZERO;
    end else begin
      case (state_ff)
        mac_pkg::ST_IDLE: begin
          nxt_state = mac_pkg::ST_HUNT;
        end
        mac_pkg::ST_HUNT: begin
          // Leading zeros skipped, first one is start
          if (sclk_rise && sdi) begin
            nxt_state = mac_pkg::ST_CFG;
            nxt_cnt = mac_pkg::CNT_ZERO;
          end
        end
        mac_pkg::ST_CFG: begin
          if (sclk_rise) begin
            nxt_cfg = {cfg_ff[1:0], sdi};
            nxt_cnt = cnt_ff + mac_pkg::CNT_ONE;
            if (cnt_ff == mac_pkg::CNT_LAST) begin
              nxt_state = mac_pkg::ST_CONV;
              nxt_mode = cfg_ff[1:0];
              nxt_order = sdi;
              nxt_start = 1'b1;
              nxt_chg = (cfg_ff[1:0] == mac_pkg::MODE_TEMP) && !prev_temp_ff;
              nxt_prev_temp = (cfg_ff[1:0] == mac_pkg::MODE_TEMP);
            end
          end
        end
        mac_pkg::ST_CONV: begin
          // Null bit with output enabled
          if (sclk_fall) begin
            nxt_state = mac_pkg::ST_SHIFT;
            nxt_oe = 1'b1;
            nxt_sdo = 1'b0;
            nxt_idx = mac_pkg::IDX_ZERO;
          end
        end
        mac_pkg::ST_SHIFT: begin
          // Input ignored; result bits on each falling edge
          if (sclk_fall) begin
            nxt_sdo = out_bit;
            if (idx_ff != mac_pkg::IDX_ALL_END) begin
              nxt_idx = idx_ff + mac_pkg::IDX_ONE;
            end
          end
        end
        default: begin
          nxt_state = mac_pkg::ST_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // Register sequencing state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_ff <= mac_pkg::ST_IDLE;
      cnt_ff <= mac_pkg::CNT_ZERO;
      cfg_ff <= 3'h0;
      mode_ff <= mac_pkg::MODE_RST;
      order_ff <= 1'b0;
      start_ff <= 1'b0;
      prev_temp_ff <= 1'b0;
      chg_ff <= 1'b0;
      idx_ff <= mac_pkg::IDX_ZERO;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cfg_ff <= nxt_cfg;
      mode_ff <= nxt_mode;
      order_ff <= nxt_order;
      start_ff <= nxt_start;
      prev_temp_ff <= nxt_prev_temp;
      chg_ff <= nxt_chg;
      idx_ff <= nxt_idx;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result capture, unsigned code passed unchanged
  always_comb begin
    nxt_code = code_ff;
    if (conv_valid) begin
      nxt_code = conv_code;
    end
  end

  // Register result
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      code_ff <= mac_pkg::CODE_RST;
    end else begin
      code_ff <= nxt_code;
    end
  end

  // Outputs
  assign sdo = sdo_ff;
  assign sdo_oe = oe_ff;
  assign conv_start = start_ff;
  assign meas_mode = mode_ff;
  assign mode_is_temp = (mode_ff == mac_pkg::MODE_TEMP);
  assign temp_after_change = chg_ff;
  assign output_order_flag = order_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic exp_lsb;
  assign exp_lsb = code_ff[lsb_sel[3:0]];

  a_idle_float: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_n |=> !sdo_oe && state_ff == mac_pkg::ST_IDLE)
    else $error("output not floated after select high");
  a_cfg_float: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_ff == mac_pkg::ST_HUNT || state_ff == mac_pkg::ST_CFG) |-> !sdo_oe)
    else $error("output driven while word received");
  a_duplex_order: assert property (@(posedge clk_sys) disable iff (!rstn)
    sdo_oe |-> state_ff == mac_pkg::ST_SHIFT)
    else $error("output driven outside result phase");
  a_zero_skip: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == mac_pkg::ST_HUNT && !cs_n && sclk_rise && !sdi
    |=> state_ff == mac_pkg::ST_HUNT)
    else $error("leading zero taken as start");
  a_start_seen: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == mac_pkg::ST_HUNT && !cs_n && sclk_rise && sdi
    |=> state_ff == mac_pkg::ST_CFG && cnt_ff == mac_pkg::CNT_ZERO)
    else $error("start bit missed");
  a_word_done: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == mac_pkg::ST_CFG && !cs_n && sclk_rise && cnt_ff == mac_pkg::CNT_LAST
    |=> conv_start && meas_mode == $past(cfg_ff[1:0]) && output_order_flag == $past(sdi)
    ##1 !conv_start)
    else $error("configuration word not applied");
  a_temp_map: assert property (@(posedge clk_sys) disable iff (!rstn)
    conv_start |-> mode_is_temp == ($past(cfg_ff[1:0]) == mac_pkg::MODE_TEMP))
    else $error("temperature mode misdecoded");
  a_temp_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    conv_start |-> temp_after_change == (mode_is_temp && !$past(prev_temp_ff)))
    else $error("mode change flag wrong");
  a_input_locked: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_ff == mac_pkg::ST_CONV || state_ff == mac_pkg::ST_SHIFT) && !cs_n
    |=> (state_ff == mac_pkg::ST_CONV || state_ff == mac_pkg::ST_SHIFT) && !conv_start)
    else $error("input accepted after word complete");
  a_null_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == mac_pkg::ST_CONV && !cs_n && sclk_fall
    |=> sdo_oe && !sdo && idx_ff == mac_pkg::IDX_ZERO)
    else $error("null bit wrong");
  a_msb_first: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == mac_pkg::ST_SHIFT && !cs_n && sclk_fall && idx_ff == mac_pkg::IDX_ZERO
    |=> sdo == code_ff[RES_W-1])
    else $error("first result bit not MSB");
  a_zero_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == mac_pkg::ST_SHIFT && !cs_n && sclk_fall && order_ff
    && idx_ff >= mac_pkg::IDX_RES_END |=> !sdo)
    else $error("fill bit not zero");
  a_lsb_repeat: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_ff == mac_pkg::ST_SHIFT && !cs_n && sclk_fall && !order_ff
    && idx_ff >= mac_pkg::IDX_RES_END && idx_ff < mac_pkg::IDX_ALL_END
    |=> sdo == $past(exp_lsb))
    else $error("LSB-first copy wrong");
endmodule // mac_ctrl

/* File: sim/mac_host.sv */
// Host model driving select, shift clock and data in
`timescale 1ns/1ps
module mac_host (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // Idle link
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Wait n system cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One shift period: data set after the fall, read at the rise
  task automatic bit_cyc(input logic d, output logic q);
    sdi = d;
    tick(4);
    sclk = 1'b1;
    q = sdo;
    tick(4);
    sclk = 1'b0;
  endtask
  // Whole exchange; cut below 4 raises select inside the word
  task automatic xfer(input int zeros, input logic [1:0] mode, input logic flag,
    input int cut, output logic [24:0] rx, output logic oe_cfg, output logic oe_rd,
    output logic oe_end);
    logic [3:0] word;
    logic q;
    word = {1'b1, mode, flag};
    oe_cfg = 1'b0;
    oe_rd = 1'b1;
    rx = '0;
    cs_n = 1'b0;
    tick((mode == 2'h0) ? 10000 : 1250);
    for (int i = 0; i < zeros; i++) bit_cyc(1'b0, q);
    for (int i = 0; i < cut; i++) begin
      bit_cyc(word[3-i], q);
      oe_cfg |= sdo_oe;
    end
    if (cut == 4) begin
      for (int i = 0; i < 25; i++) begin
        bit_cyc(~sdi, q);
        rx[24-i] = q;
        oe_rd &= sdo_oe;
      end
    end
    cs_n = 1'b1;
    tick(2);
    oe_end = sdo_oe;
    tick(4);
  endtask
endmodule // mac_host

/* File: sim/mac_ctrl_test.sv */
// Testbench for the monitor serial control
`timescale 1ns/1ps
module mac_ctrl_test;
  logic clk_sys, rstn, cs_n, sclk, sdi, sdo, sdo_oe, conv_start, mode_is_temp;
  logic temp_after_change, output_order_flag, conv_valid;
  logic [1:0] meas_mode;
  logic [9:0] conv_code;
  logic [24:0] rx, exp_rx;
  logic oe_cfg, oe_rd, oe_end;
  int fails, tests_run;
  mac_ctrl u_mac_ctrl (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .conv_start(conv_start),
    .meas_mode(meas_mode), .mode_is_temp(mode_is_temp),
    .temp_after_change(temp_after_change), .output_order_flag(output_order_flag),
    .conv_valid(conv_valid), .conv_code(conv_code));
  mac_host u_mac_host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));
  ////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Converter stand-in answers each start pulse
  always @(posedge clk_sys) begin
    #1 conv_valid = conv_start;
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict
  task automatic finish_test;
    $display("Counts: %0d compared, %0d bad", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One full exchange with its expectations
  task automatic run(input int n, input int zeros, input logic [1:0] mode,
    input logic flag, input logic [9:0] code, input logic exp_tac);
    conv_code = code;
    exp_rx = {1'b0, code, 14'h0000};
    if (!flag) begin
      for (int i = 0; i < 10; i++) exp_rx[13-i] = code[i];
    end
    u_mac_host.xfer(zeros, mode, flag, 4, rx, oe_cfg, oe_rd, oe_end);
    check(rx, exp_rx);
    check(oe_cfg, 1'b0);
    check(oe_rd, 1'b1);
    check(oe_end, 1'b0);
    check(meas_mode, mode);
    check(mode_is_temp, mode == 2'h0);
    check(output_order_flag, flag);
    check(temp_after_change, exp_tac);
    $display("test %0d done", n);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    rstn = 1'b0;
    conv_valid = 1'b0;
    conv_code = 10'h000;
    repeat (4) @(posedge clk_sys);
    #1 rstn = 1'b1;
    check(sdo_oe, 1'b0);
    check(meas_mode, 2'h1);
    check(output_order_flag, 1'b0);
    check(temp_after_change, 1'b0);
    check(conv_start, 1'b0);
    $display("test 0 done");
    run(1, 0, 2'h0, 1'b1, 10'h26c, 1'b1);
    run(2, 3, 2'h0, 1'b0, 10'h3ff, 1'b0);
    run(3, 0, 2'h1, 1'b0, 10'h222, 1'b0);
    u_mac_host.xfer(1, 2'h3, 1'b0, 2, rx, oe_cfg, oe_rd, oe_end);
    check(oe_end, 1'b0);
    check(meas_mode, 2'h1);
    $display("test abort done");
    run(4, 1, 2'h0, 1'b0, 10'h155, 1'b1);
    run(5, 0, 2'h2, 1'b1, 10'h001, 1'b0);
    run(6, 2, 2'h3, 1'b0, 10'h200, 1'b0);
    finish_test;
  end
endmodule // mac_ctrl_test
